//--- pkg/smr_pkg.sv
// Constants and carrier types shared by the message ring engine.
package smr_pkg;

   // Register byte offsets on the APB side.
   localparam logic [7:0]  SMR_CTRL_OFS   = 8'h00;
   localparam logic [7:0]  SMR_SEGB_OFS   = 8'h04;
   localparam logic [7:0]  SMR_INHD_OFS   = 8'h08;
   localparam logic [7:0]  SMR_OUTHD_OFS  = 8'h0c;
   localparam logic [7:0]  SMR_RSVLO_OFS  = 8'h10;
   localparam logic [7:0]  SMR_RSVHI_OFS  = 8'h14;
   localparam logic [7:0]  SMR_PTRS_OFS   = 8'h18;
   localparam logic [7:0]  SMR_STAT_OFS   = 8'h1c;

   // Control register fields and reset values.
   localparam int          SMR_CTRL_EN_BIT = 0;
   localparam int          SMR_CTRL_FE_BIT = 1;
   localparam logic [1:0]  SMR_CTRL_RST    = 2'h0;
   localparam logic [31:0] SMR_WORD_RST    = 32'h0000_0000;
   localparam logic [15:0] SMR_HALF_RST    = 16'h0000;

   // Buffer status byte fields.
   localparam int          SMR_OWN_BIT  = 0;
   localparam int          SMR_DONE_BIT = 1;
   localparam int          SMR_OVF_BIT  = 2;
   localparam logic [7:0]  SMR_ST_HAND  = 8'hf8;

   // Byte offsets of the buffer fields within a ring buffer.
   localparam logic [15:0] SMR_F_LINK   = 16'h0000;
   localparam logic [15:0] SMR_F_STATUS = 16'h0003;
   localparam logic [15:0] SMR_F_LEN    = 16'h0004;
   localparam logic [15:0] SMR_F_DATA   = 16'h0006;

   // Download request layout inside the data field.
   localparam logic [15:0] SMR_REQ_LEN  = 16'h0012;
   localparam int          SMR_M_CODE   = 6;
   localparam int          SMR_M_RC     = 7;
   localparam int          SMR_M_DLEN   = 8;
   localparam int          SMR_M_SRC    = 10;
   localparam int          SMR_M_DST    = 14;
   localparam int          SMR_HDR_N    = 18;
   localparam logic [7:0]  SMR_CODE_DL  = 8'h00;
   localparam logic [7:0]  SMR_RC_OK    = 8'h00;
   localparam logic [7:0]  SMR_RC_OVL   = 8'ha3;
   localparam logic [7:0]  SMR_RC_NOFE  = 8'ha1;

   // One byte access to shared memory.
   typedef struct packed {
      logic        we;
      logic [31:0] addr;
      logic [7:0]  wdata;
   } smr_mreq_s;

endpackage

//--- design/smr_sync2.sv
// Two-flop synchroniser for a level arriving from a host pin.
`timescale 1ns/10ps
module smr_sync2 (
   input  wire logic clock,
   input  wire logic resetn,
   input  wire logic d,
   output logic      q
);
   logic meta_r;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         meta_r <= 1'b0;
         q      <= 1'b0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule

//--- design/smr_mem_acc.sv
// Single byte access master towards shared memory.
`timescale 1ns/10ps
module smr_mem_acc (
   input  wire logic              clock,
   input  wire logic              resetn,
   input  wire logic              start,
   input  wire smr_pkg::smr_mreq_s req,
   output logic                   done,
   output logic [7:0]             rdata,
   output logic                   mem_req,
   output logic                   mem_we,
   output logic [31:0]            mem_addr,
   output logic [7:0]             mem_wdata,
   input  wire logic [7:0]        mem_rdata,
   input  wire logic              mem_ack
);
   import smr_pkg::*;

   // The request is held until the memory acknowledges it.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         mem_req   <= 1'b0;
         mem_we    <= 1'b0;
         mem_addr  <= SMR_WORD_RST;
         mem_wdata <= 8'h00;
         done      <= 1'b0;
         rdata     <= 8'h00;
      end else begin
         done <= 1'b0;
         if (mem_req && mem_ack) begin
            mem_req <= 1'b0;
            done    <= 1'b1;
            rdata   <= mem_rdata;
         end else if (start && !mem_req) begin
            mem_req   <= 1'b1;
            mem_we    <= req.we;
            mem_addr  <= req.addr;
            mem_wdata <= req.wdata;
         end
      end
   end
endmodule

//--- design/smr_ring.sv
// Message ring engine: two shared-memory rings, doorbell and host interrupt.
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/10ps
module smr_ring (
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        doorbell_pin,
   input  wire logic        irq_ack_pin,
   output logic             host_irq,
   output logic             mem_req,
   output logic             mem_we,
   output logic [31:0]      mem_addr,
   output logic [7:0]       mem_wdata,
   input  wire logic [7:0]  mem_rdata,
   input  wire logic        mem_ack,
   output logic             um_we,
   output logic [31:0]      um_addr,
   output logic [7:0]       um_wdata,
   input  wire logic        rx_req,
   output logic             usr_valid,
   output logic [7:0]       usr_data,
   output logic             usr_last,
   input  wire logic        usr_ready
);
   import smr_pkg::*;

   typedef enum logic [4:0] {
      S_IDLE, S_CHK, S_LNK0, S_LNK1, S_LEN0, S_LEN1, S_IN_HDR, S_DISP,
      S_USR_WAIT, S_USR_RD, S_USR_SEND, S_CP_RD, S_CP_WR, S_RET,
      S_OUT_DAT, S_OUT_NW0, S_OUT_NW1, S_OUT_STW
   } smr_state_e;

   // Shared memory address of a buffer field; the offset wraps in the segment.
   function automatic logic [31:0] sh_addr(input logic [31:0] base,
                                           input logic [15:0] ofs,
                                           input logic [15:0] k);
      return base + {16'h0000, ofs + k};
   endfunction

   function automatic logic [15:0] min16(input logic [15:0] a,
                                         input logic [15:0] b);
      return (a < b) ? a : b;
   endfunction

   smr_state_e  state_r;
   logic [1:0]  ctrl_r;
   logic [31:0] segb_r, rsvlo_r, rsvhi_r;
   logic [15:0] inhd_r, outhd_r;
   logic [15:0] in_ptr_r, out_ptr_r, cur_r, idx_r, len_r, lnk_lo_r;
   logic [15:0] cnt_r, nin_r;
   logic [7:0]  st_r, rc_r, byte_r;
   logic [7:0]  hdr_r [0:SMR_HDR_N-1];
   logic        dir_r, is_dl_r, reply_pend_r, out_wait_r, in_more_r;
   logic        db_pend_r, db_q_d_r, ack_q_d_r, acc_wait_r;
   logic        db_q, ack_q, db_rise, ack_rise, db_take, irq_set;
   logic        apb_wr, ptr_load, acc_start, acc_done, mem_state;
   logic [7:0]  acc_rdata;
   smr_mreq_s   acc_req;
   logic [15:0] hn, olen, dlen;
   logic [31:0] src, dst;

   smr_sync2 u_db (.clock(clock), .resetn(resetn), .d(doorbell_pin),
                   .q(db_q));
   smr_sync2 u_ack (.clock(clock), .resetn(resetn), .d(irq_ack_pin),
                    .q(ack_q));

   smr_mem_acc u_acc (
      .clock(clock), .resetn(resetn), .start(acc_start), .req(acc_req),
      .done(acc_done), .rdata(acc_rdata), .mem_req(mem_req),
      .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata), .mem_ack(mem_ack)
   );

   assign db_rise  = db_q & ~db_q_d_r;
   assign ack_rise = ack_q & ~ack_q_d_r;
   assign apb_wr   = psel & penable & pready & pwrite & ~pslverr;
   assign ptr_load = apb_wr & (paddr == SMR_CTRL_OFS)
                     & pwdata[SMR_CTRL_EN_BIT] & ~ctrl_r[SMR_CTRL_EN_BIT];
   assign hn       = min16(len_r, SMR_REQ_LEN);
   assign olen     = min16(len_r, SMR_REQ_LEN);
   assign dlen     = {hdr_r[SMR_M_DLEN+1], hdr_r[SMR_M_DLEN]};
   assign src      = {hdr_r[SMR_M_SRC+3], hdr_r[SMR_M_SRC+2],
                      hdr_r[SMR_M_SRC+1], hdr_r[SMR_M_SRC]};
   assign dst      = {hdr_r[SMR_M_DST+3], hdr_r[SMR_M_DST+2],
                      hdr_r[SMR_M_DST+1], hdr_r[SMR_M_DST]};
   assign db_take  = (state_r == S_IDLE) && ctrl_r[SMR_CTRL_EN_BIT]
                     && db_pend_r && !(reply_pend_r && !out_wait_r);
   assign irq_set  = acc_done && (state_r == S_RET || state_r == S_OUT_STW);

   // Reply byte: tag and code come back untouched, return code and count replaced.
   function automatic logic [7:0] reply_byte(input logic [15:0] k);
      logic [7:0] b;
      b = hdr_r[k[4:0]];
      if (k == 16'(SMR_M_RC)) b = rc_r;
      if (k == 16'(SMR_M_DLEN)) b = cnt_r[7:0];
      if (k == 16'(SMR_M_DLEN + 1)) b = cnt_r[15:8];
      return b;
   endfunction

   // Shared memory access issued by the current state.
   always_comb begin
      acc_req   = '{we: 1'b0, addr: SMR_WORD_RST, wdata: 8'h00};
      mem_state = 1'b1;
      unique case (state_r)
         S_CHK:      acc_req.addr = sh_addr(segb_r,
                        dir_r ? out_ptr_r : in_ptr_r, SMR_F_STATUS);
         S_LNK0:     acc_req.addr = sh_addr(segb_r, cur_r, SMR_F_LINK);
         S_LNK1:     acc_req.addr = sh_addr(segb_r, cur_r, SMR_F_LINK + 1'b1);
         S_LEN0:     acc_req.addr = sh_addr(segb_r, cur_r, SMR_F_LEN);
         S_LEN1:     acc_req.addr = sh_addr(segb_r, cur_r, SMR_F_LEN + 1'b1);
         S_IN_HDR,
         S_USR_RD:   acc_req.addr = sh_addr(segb_r, cur_r, SMR_F_DATA + idx_r);
         S_CP_RD:    acc_req.addr = src + {16'h0000, idx_r};
         S_RET: begin
            acc_req.we    = 1'b1;
            acc_req.addr  = sh_addr(segb_r, cur_r, SMR_F_STATUS);
            acc_req.wdata = st_r & SMR_ST_HAND;
         end
         S_OUT_DAT: begin
            acc_req.we    = 1'b1;
            acc_req.addr  = sh_addr(segb_r, cur_r, SMR_F_DATA + idx_r);
            acc_req.wdata = reply_byte(idx_r);
         end
         S_OUT_NW0: begin
            acc_req.we    = 1'b1;
            acc_req.addr  = sh_addr(segb_r, cur_r, SMR_F_LEN);
            acc_req.wdata = olen[7:0];
         end
         S_OUT_NW1: begin
            acc_req.we    = 1'b1;
            acc_req.addr  = sh_addr(segb_r, cur_r, SMR_F_LEN + 1'b1);
            acc_req.wdata = olen[15:8];
         end
         S_OUT_STW: begin
            acc_req.we    = 1'b1;
            acc_req.addr  = sh_addr(segb_r, cur_r, SMR_F_STATUS);
            acc_req.wdata = (st_r & SMR_ST_HAND)
                            | {5'h00, len_r < SMR_REQ_LEN, 2'b00};
         end
         default:    mem_state = 1'b0;
      endcase
      // An empty field moves nothing; a stray read would complete a later step.
      if ((state_r == S_IN_HDR && hn == SMR_HALF_RST)
          || (state_r == S_OUT_DAT && olen == SMR_HALF_RST))
         mem_state = 1'b0;
   end

   assign acc_start = mem_state & ~acc_wait_r;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) acc_wait_r <= 1'b0;
      else if (acc_done) acc_wait_r <= 1'b0;
      else if (acc_start) acc_wait_r <= 1'b1;
   end

   // Pin edges; a doorbell arriving while one is consumed is kept.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         db_q_d_r  <= 1'b0;
         ack_q_d_r <= 1'b0;
         db_pend_r <= 1'b0;
      end else begin
         db_q_d_r  <= db_q;
         ack_q_d_r <= ack_q;
         db_pend_r <= db_rise | (db_pend_r & ~db_take);
      end
   end

   // Host interrupt: raised on every hand-over, dropped by acknowledge.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) host_irq <= 1'b0;
      else host_irq <= irq_set | (host_irq & ~ack_rise);
   end

   // Main ring sequencer.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_r      <= S_IDLE;
         in_ptr_r     <= SMR_HALF_RST;
         out_ptr_r    <= SMR_HALF_RST;
         cur_r        <= SMR_HALF_RST;
         idx_r        <= SMR_HALF_RST;
         len_r        <= SMR_HALF_RST;
         lnk_lo_r     <= SMR_HALF_RST;
         cnt_r        <= SMR_HALF_RST;
         nin_r        <= SMR_HALF_RST;
         st_r         <= 8'h00;
         rc_r         <= 8'h00;
         byte_r       <= 8'h00;
         dir_r        <= 1'b0;
         is_dl_r      <= 1'b0;
         reply_pend_r <= 1'b0;
         out_wait_r   <= 1'b0;
         in_more_r    <= 1'b0;
         usr_valid    <= 1'b0;
         usr_data     <= 8'h00;
         usr_last     <= 1'b0;
         um_we        <= 1'b0;
         um_addr      <= SMR_WORD_RST;
         um_wdata     <= 8'h00;
         for (int i = 0; i < SMR_HDR_N; i++) hdr_r[i] <= 8'h00;
      end else begin
         um_we <= 1'b0;
         if (ptr_load) begin
            in_ptr_r  <= inhd_r;
            out_ptr_r <= outhd_r;
         end
         unique case (state_r)
            S_IDLE: if (ctrl_r[SMR_CTRL_EN_BIT] && !ptr_load) begin
               if (reply_pend_r && !out_wait_r) begin
                  dir_r   <= 1'b1;
                  state_r <= S_CHK;
               end else if (reply_pend_r && db_pend_r) begin
                  out_wait_r <= 1'b0;
                  in_more_r  <= 1'b1;
               end else if (!reply_pend_r && (db_pend_r || in_more_r)) begin
                  dir_r   <= 1'b0;
                  state_r <= S_CHK;
               end
            end
            S_CHK: if (acc_done) begin
               st_r  <= acc_rdata;
               cur_r <= dir_r ? out_ptr_r : in_ptr_r;
               if (!acc_rdata[SMR_OWN_BIT]) begin
                  if (dir_r) out_wait_r <= 1'b1;
                  else in_more_r <= 1'b0;
                  state_r <= S_IDLE;
               end else begin
                  state_r <= S_LNK0;
               end
            end
            S_LNK0: if (acc_done) begin
               lnk_lo_r <= {8'h00, acc_rdata};
               state_r  <= S_LNK1;
            end
            S_LNK1: if (acc_done) begin
               if (dir_r) out_ptr_r <= {acc_rdata, lnk_lo_r[7:0]};
               else in_ptr_r <= {acc_rdata, lnk_lo_r[7:0]};
               state_r <= S_LEN0;
            end
            S_LEN0: if (acc_done) begin
               len_r   <= {8'h00, acc_rdata};
               state_r <= S_LEN1;
            end
            S_LEN1: if (acc_done) begin
               len_r   <= {acc_rdata, len_r[7:0]};
               idx_r   <= SMR_HALF_RST;
               state_r <= dir_r ? S_OUT_DAT : S_IN_HDR;
            end
            S_IN_HDR: if (hn == SMR_HALF_RST) begin
               state_r <= S_DISP;
            end else if (acc_done) begin
               hdr_r[idx_r[4:0]] <= acc_rdata;
               if (idx_r == hn - 1'b1) begin
                  idx_r   <= SMR_HALF_RST;
                  state_r <= S_DISP;
               end else begin
                  idx_r <= idx_r + 1'b1;
               end
            end
            S_DISP: begin
               cnt_r <= SMR_HALF_RST;
               if (len_r >= SMR_REQ_LEN && hdr_r[SMR_M_CODE] == SMR_CODE_DL) begin
                  is_dl_r <= 1'b1;
                  rc_r    <= SMR_RC_OK;
                  if (!ctrl_r[SMR_CTRL_FE_BIT]) begin
                     rc_r    <= SMR_RC_NOFE;
                     state_r <= S_RET;
                  end else if (dlen != SMR_HALF_RST && dst <= rsvhi_r
                     && dst + {16'h0000, dlen} - 32'h0000_0001 >= rsvlo_r) begin
                     rc_r    <= SMR_RC_OVL;
                     state_r <= S_RET;
                  end else begin
                     state_r <= (dlen == SMR_HALF_RST) ? S_RET : S_CP_RD;
                  end
               end else begin
                  is_dl_r <= 1'b0;
                  state_r <= (len_r == SMR_HALF_RST) ? S_RET : S_USR_WAIT;
               end
            end
            S_USR_WAIT: if (rx_req) state_r <= S_USR_RD;
            S_USR_RD: if (acc_done) begin
               usr_data  <= acc_rdata;
               usr_valid <= 1'b1;
               usr_last  <= (idx_r == len_r - 1'b1);
               state_r   <= S_USR_SEND;
            end
            S_USR_SEND: if (usr_ready) begin
               usr_valid <= 1'b0;
               usr_last  <= 1'b0;
               idx_r     <= idx_r + 1'b1;
               state_r   <= usr_last ? S_RET : S_USR_RD;
            end
            S_CP_RD: if (acc_done) begin
               byte_r  <= acc_rdata;
               state_r <= S_CP_WR;
            end
            S_CP_WR: begin
               um_we    <= 1'b1;
               um_addr  <= dst + {16'h0000, idx_r};
               um_wdata <= byte_r;
               cnt_r    <= idx_r + 1'b1;
               idx_r    <= idx_r + 1'b1;
               state_r  <= (idx_r == dlen - 1'b1) ? S_RET : S_CP_RD;
            end
            S_RET: if (acc_done) begin
               nin_r        <= nin_r + 1'b1;
               reply_pend_r <= is_dl_r;
               in_more_r    <= 1'b1;
               state_r      <= S_IDLE;
            end
            S_OUT_DAT: if (olen == SMR_HALF_RST) begin
               state_r <= S_OUT_NW0;
            end else if (acc_done) begin
               idx_r   <= idx_r + 1'b1;
               state_r <= (idx_r == olen - 1'b1) ? S_OUT_NW0 : S_OUT_DAT;
            end
            S_OUT_NW0: if (acc_done) state_r <= S_OUT_NW1;
            S_OUT_NW1: if (acc_done) state_r <= S_OUT_STW;
            S_OUT_STW: if (acc_done) begin
               reply_pend_r <= 1'b0;
               in_more_r    <= 1'b1;
               state_r      <= S_IDLE;
            end
         endcase
      end
   end

   // APB slave: one wait-free access phase, error on unmapped words.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= SMR_WORD_RST;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         prdata  <= SMR_WORD_RST;
         if (psel && !penable) begin
            unique case (paddr)
               SMR_CTRL_OFS:  prdata <= {30'h0, ctrl_r};
               SMR_SEGB_OFS:  prdata <= segb_r;
               SMR_INHD_OFS:  prdata <= {16'h0000, inhd_r};
               SMR_OUTHD_OFS: prdata <= {16'h0000, outhd_r};
               SMR_RSVLO_OFS: prdata <= rsvlo_r;
               SMR_RSVHI_OFS: prdata <= rsvhi_r;
               SMR_PTRS_OFS:  prdata <= {out_ptr_r, in_ptr_r};
               SMR_STAT_OFS:  prdata <= {nin_r, 9'h000, state_r != S_IDLE,
                                         host_irq, reply_pend_r, out_wait_r,
                                         in_more_r, db_pend_r, 1'b0};
               default:       pslverr <= 1'b1;
            endcase
         end
      end
   end

   // Software-written configuration.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ctrl_r  <= SMR_CTRL_RST;
         segb_r  <= SMR_WORD_RST;
         inhd_r  <= SMR_HALF_RST;
         outhd_r <= SMR_HALF_RST;
         rsvlo_r <= SMR_WORD_RST;
         rsvhi_r <= SMR_WORD_RST;
      end else if (apb_wr) begin
         unique case (paddr)
            SMR_CTRL_OFS:  ctrl_r  <= pwdata[1:0];
            SMR_SEGB_OFS:  segb_r  <= pwdata;
            SMR_INHD_OFS:  inhd_r  <= pwdata[15:0];
            SMR_OUTHD_OFS: outhd_r <= pwdata[15:0];
            SMR_RSVLO_OFS: rsvlo_r <= pwdata;
            SMR_RSVHI_OFS: rsvhi_r <= pwdata;
            default:       ;
         endcase
      end
   end
endmodule

//--- sim/smr_ring_assertions.sv
// Checker bound to the message ring engine ports.
`timescale 1ns/10ps
module smr_ring_assertions (
   input wire logic        clock,
   input wire logic        resetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        irq_ack_pin,
   input wire logic        host_irq,
   input wire logic        mem_req,
   input wire logic        mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [7:0]  mem_wdata,
   input wire logic        mem_ack,
   input wire logic        um_we
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   sequence s_taken;
      mem_req && mem_ack;
   endsequence
   // The acknowledge pin needs three edges before the engine sees it.
   sequence s_ack_seen;
      $rose(irq_ack_pin) ##3 1'b1;
   endsequence
   a_apb_answer: assert property (psel && !penable |=> pready)
      else $error("pready missing in access phase");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_mem_hold: assert property (mem_req && !mem_ack |=> mem_req
      && $stable(mem_addr) && $stable(mem_wdata))
      else $error("memory request changed before ack");
   a_mem_release: assert property (s_taken |=> !mem_req)
      else $error("memory request held after ack");
   a_irq_cause: assert property ($rose(host_irq)
      |-> $past(mem_req && mem_we && mem_ack, 2))
      else $error("interrupt without a finished write");
   a_irq_owner: assert property ($rose(host_irq)
      |-> $past(mem_wdata[1:0]) == 2'b00)
      else $error("handover write kept owner or done");
   a_ack_drop: assert property (s_ack_seen |-> ##[0:4] !host_irq)
      else $error("interrupt not dropped after ack");
   a_um_pulse: assert property (um_we |=> !um_we)
      else $error("user write longer than one cycle");
endmodule
bind smr_ring smr_ring_assertions i_smr_ring_assertions (
   .clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .irq_ack_pin(irq_ack_pin),
   .host_irq(host_irq), .mem_req(mem_req), .mem_we(mem_we),
   .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
   .um_we(um_we));

//--- sim/smr_mem_model.sv
// Shared memory seen by the engine, prompt or slow to answer.
`timescale 1ns/10ps
module smr_mem_model (
   input  wire logic        clock,
   input  wire logic        slow,
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [31:0] mem_addr,
   input  wire logic [7:0]  mem_wdata,
   output logic [7:0]       mem_rdata,
   output logic             mem_ack
);
   logic [7:0] m [0:511];
   logic [1:0] wt = 2'h0;
   initial mem_rdata = 8'h00;
   initial mem_ack = 1'b0;
   initial foreach (m[i]) m[i] = 8'h00;
   // Outside an answer the data lines toggle so stale data never matches.
   always @(posedge clock) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
         wt <= wt + 2'h1;
         if (wt >= {slow, slow}) begin
            wt <= 2'h0;
            mem_ack <= 1'b1;
            mem_rdata <= m[mem_addr[8:0]];
            if (mem_we)
               m[mem_addr[8:0]] <= mem_wdata;
         end
      end
   end
endmodule

//--- sim/smr_ring_tb_top.sv
// Testbench for the message ring engine.
`timescale 1ns/10ps
module smr_ring_tb_top;
   import smr_pkg::*;
   logic        clock = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, db = 1'b0, ack = 1'b0, slow = 1'b1, e;
   logic        rx = 1'b1, uv, ul;
   logic [7:0]  paddr = 8'h00, mem_wdata, mem_rdata, um_wdata, ud;
   logic [31:0] pwdata = 32'h0, prdata, r, mem_addr, um_addr;
   logic        pready, pslverr, host_irq, mem_req, mem_we, mem_ack, um_we;
   logic [39:0] umq[$];
   logic [8:0]  usq[$];
   int          bad_count = 0, checked = 0;
   always #12.5 clock = ~clock;
   always @(posedge clock) if (um_we) umq.push_back({um_addr, um_wdata});
   always @(posedge clock) if (uv) usq.push_back({ul, ud});
   smr_ring i_smr_ring (.clock(clock), .resetn(resetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .doorbell_pin(db), .irq_ack_pin(ack), .host_irq(host_irq),
      .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
      .um_we(um_we), .um_addr(um_addr), .um_wdata(um_wdata),
      .rx_req(rx), .usr_valid(uv), .usr_data(ud), .usr_last(ul),
      .usr_ready(1'b1));
   smr_mem_model i_smr_mem_model (.clock(clock), .slow(slow),
      .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
   task automatic chk(input string n, input logic [39:0] s, x);
      checked++;
      if (s !== x) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", n, x, s);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input int d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic put(input int a, input logic [15:0] v);
      i_smr_mem_model.m[a] = v[7:0];
      i_smr_mem_model.m[a+1] = v[15:8];
   endtask
   task automatic mc(input string n, input int a, input logic [7:0] x);
      chk(n, i_smr_mem_model.m[a], x);
   endtask
   // Host side: fields first, owner bit last, strictly in ring order.
   task automatic req(input int b, lk, input logic [7:0] t, input int d);
      logic [143:0] v;
      v = {d, 32'h1c0, 16'h2, 16'h0, {4{t}}, 16'h0};
      put(b, lk[15:0]);
      put(b + 4, 16'h12);
      for (int i = 0; i < 18; i++) i_smr_mem_model.m[b+6+i] = v[8*i+:8];
      i_smr_mem_model.m[b+3] = 8'h01;
   endtask
   task automatic wait_mem(input int a, input logic [7:0] x);
      int n = 0;
      while (i_smr_mem_model.m[a] !== x && n < 3000) begin
         @(posedge clock);
         n++;
      end
      mc("status", a, x);
   endtask
   task automatic ring(input logic bell);
      {db, ack} <= bell ? 2'b10 : 2'b01;
      repeat (4) @(posedge clock);
      {db, ack} <= 2'b00;
      repeat (4) @(posedge clock);
   endtask
   task automatic give_verdict;
      $display("checked %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clock);
      bad_count++;
      give_verdict;
   end
   initial begin
      repeat (4) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      apb(0, SMR_CTRL_OFS, 0);
      chk("ctrl", r, 32'h0);
      apb(0, 8'h20, 0);
      chk("unmapped", e, 1'b1);
      apb(1, SMR_RSVLO_OFS, 32'h2000);
      apb(1, SMR_RSVHI_OFS, 32'h2fff);
      apb(0, SMR_RSVHI_OFS, 0);
      chk("rsvhi", r, 32'h2fff);
      apb(1, SMR_INHD_OFS, 32'h40);
      apb(1, SMR_OUTHD_OFS, 32'h100);
      put(16'h100, 16'h140);
      put(16'h104, 16'h20);
      put(16'h140, 16'h100);
      put(16'h144, 16'h20);
      put(16'h1c0, 16'ha55a);
      i_smr_mem_model.m[16'h103] = 8'h03;
      i_smr_mem_model.m[16'h143] = 8'h03;
      req(16'h40, 16'h80, 8'h11, 32'h1000);
      req(16'h80, 16'h40, 8'h22, 32'h2010);
      apb(1, SMR_CTRL_OFS, 32'h3);
      ring(1);
      wait_mem(16'h143, 8'h00);
      repeat (4) @(posedge clock);
      chk("irq", host_irq, 1'b1);
      chk("copies", umq.size(), 2);
      chk("copy0", umq[0], {32'h1000, 8'h5a});
      chk("copy1", umq[1], {32'h1001, 8'ha5});
      mc("rc0", 16'h10d, 8'h00);
      mc("code", 16'h10c, SMR_CODE_DL);
      mc("tag0", 16'h10b, 8'h11);
      mc("count", 16'h10e, 8'h02);
      mc("len", 16'h104, 8'h12);
      mc("rc1", 16'h14d, 8'ha3);
      mc("tag1", 16'h14b, 8'h22);
      mc("ret0", 16'h43, 8'h00);
      mc("ret1", 16'h83, 8'h00);
      apb(0, SMR_PTRS_OFS, 0);
      chk("ptrs", r, 32'h0100_0040);
      ring(0);
      chk("irq", host_irq, 1'b0);
      $display("test download done");
      slow <= 1'b0;
      apb(1, SMR_CTRL_OFS, 32'h1);
      req(16'h40, 16'h80, 8'h33, 32'h1000);
      ring(1);
      wait_mem(16'h43, 8'h00);
      repeat (30) @(posedge clock);
      mc("held", 16'h103, 8'h00);
      apb(0, SMR_PTRS_OFS, 0);
      chk("ptrs", r, 32'h0100_0080);
      put(16'h104, 16'h10);
      i_smr_mem_model.m[16'h103] = 8'h03;
      ring(1);
      wait_mem(16'h103, 8'h04);
      mc("rc2", 16'h10d, 8'ha1);
      mc("trunc", 16'h104, 8'h10);
      $display("test reply wait done");
      ring(1);
      apb(0, SMR_PTRS_OFS, 0);
      chk("ptrs", r, 32'h0140_0080);
      $display("test spurious doorbell done");
      rx <= 1'b0;
      put(16'h80, 16'h40);
      put(16'h84, 16'h2);
      put(16'h86, 16'h6b6a);
      i_smr_mem_model.m[16'h83] = 8'h01;
      ring(1);
      repeat (40) @(posedge clock);
      apb(0, SMR_PTRS_OFS, 0);
      chk("ptrs", r, 32'h0140_0040);
      mc("stall", 16'h83, 8'h01);
      rx <= 1'b1;
      wait_mem(16'h83, 8'h00);
      chk("stream", {usq[0], usq[1]}, {9'h06a, 9'h16b});
      $display("test user stream done");
      give_verdict;
   end
endmodule
